/* logic/rgbdg_pkg.sv */
// constants shared by the dimming and output-mode register bank
// What this block does
// - Each green code step raises the sink current by 0.1mA, 256 steps.
// - A blue code of zero, like green, means the 0.1mA minimum, not off.
// - A code of all ones in either colour register means 25.6mA.
// - Both colour registers load 00000001 (0.2mA) at power-on.
// - Mode bit zero runs all three outputs as regulators, one as GPO.
// - In GPO mode bit 4 set drives pin 1 low, bit 3 set drives pin 2 low.
// - In GPO mode bit 2 set drives pin 3 low with its switch on.
// - In GPO mode a level bit of zero drives its pin high, switch off.
package rgbdg_pkg;
  localparam logic [7:0] GREEN_OFS      = 8'h22;
  localparam logic [7:0] BLUE_OFS       = 8'h23;
  localparam logic [7:0] CTRL_OFS       = 8'h24;
  localparam logic [7:0] CODE_RST       = 8'h01;
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam logic [7:0] CTRL_WMASK     = 8'h9c;
  localparam int         MODE_BIT       = 7;
  localparam int         PIN1_LVL_BIT   = 4;
  localparam int         PIN2_LVL_BIT   = 3;
  localparam int         PIN3_LVL_BIT   = 2;
  localparam int         CODE_W         = 8;
  localparam int         STEPS_W        = 9;
  localparam logic [8:0] STEP_OFS       = 9'h001;
  localparam logic [6:0] DEV_ADDR_DFLT  = 7'h4c;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  typedef enum logic [8:0] {
    RGBDG_IDLE  = 9'h001,
    RGBDG_ADDR  = 9'h002,
    RGBDG_AACK  = 9'h004,
    RGBDG_PTR   = 9'h008,
    RGBDG_PACK  = 9'h010,
    RGBDG_WDAT  = 9'h020,
    RGBDG_WACK  = 9'h040,
    RGBDG_RDAT  = 9'h080,
    RGBDG_RACK  = 9'h100
  } rgbdg_state_e;
endpackage

/* logic/rgbdg_sink_steps.sv */
// code to sink current step count, in units of 0.1mA
`timescale 1ns/10ps
module rgbdg_sink_steps #(
  parameter int CODE_W  = rgbdg_pkg::CODE_W,
  parameter int STEPS_W = rgbdg_pkg::STEPS_W
) (
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire logic [CODE_W-1:0]  code_i,
  output logic      [STEPS_W-1:0] steps_o
);
  logic [STEPS_W-1:0] steps_nxt;

  always_comb
  begin
    // zero is the minimum step, never off; all ones gives 256 steps
    steps_nxt = {1'b0, code_i} + rgbdg_pkg::STEP_OFS;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      steps_o <= rgbdg_pkg::STEP_OFS + 9'h001;
    else
      steps_o <= steps_nxt;
  end
endmodule // rgbdg_sink_steps

/* logic/rgbdg_regs.sv */
// i2c target with green, blue current codes and output mode control
`timescale 1ns/10ps
module rgbdg_regs #(
  parameter logic [6:0] DEV_ADDR = rgbdg_pkg::DEV_ADDR_DFLT
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic [7:0]      green_code_o,
  output logic [7:0]      blue_code_o,
  output logic [8:0]      green_steps_o,
  output logic [8:0]      blue_steps_o,
  output logic            gpo_mode_o,
  output logic [2:0]      pin_low_o,
  output logic [2:0]      pin_high_o
);
  logic [2:0]             scl_sync_r;
  logic [2:0]             sda_sync_r;
  logic                   scl_s;
  logic                   sda_s;
  logic                   start_det;
  logic                   stop_det;
  logic                   scl_rise;
  logic                   scl_fall;
  rgbdg_pkg::rgbdg_state_e state_r, state_nxt;
  logic [7:0]             shift_r, shift_nxt;
  logic [3:0]             cnt_r, cnt_nxt;
  logic [7:0]             ptr_r, ptr_nxt;
  logic                   drive_r, drive_nxt;
  logic                   nack_r, nack_nxt;
  logic [7:0]             green_r, green_nxt;
  logic [7:0]             blue_r, blue_nxt;
  logic [7:0]             ctrl_r, ctrl_nxt;
  logic                   wr_en;
  logic [2:0]             lvl;
  logic [2:0]             pin_low_nxt;
  logic [2:0]             pin_high_nxt;
  logic [7:0]             steps_code [2];
  logic [8:0]             steps_out [2];

  // register read decode, shared by the first and following read bytes
  function automatic logic [7:0] rd_value(input logic [7:0] ofs,
                                          input logic [7:0] g,
                                          input logic [7:0] b,
                                          input logic [7:0] c);
    case (ofs)
      rgbdg_pkg::GREEN_OFS: return g;
      rgbdg_pkg::BLUE_OFS:  return b;
      rgbdg_pkg::CTRL_OFS:  return c & rgbdg_pkg::CTRL_WMASK;
      default:              return 8'h00;
    endcase
  endfunction

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[1:0], scl_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
    end
  end

  always_comb
  begin
    scl_s     = scl_sync_r[1];
    sda_s     = sda_sync_r[1];
    start_det = scl_s & scl_sync_r[2] & sda_sync_r[2] & ~sda_s;
    stop_det  = scl_s & scl_sync_r[2] & ~sda_sync_r[2] & sda_s;
    scl_rise  = scl_s & ~scl_sync_r[2];
    scl_fall  = ~scl_s & scl_sync_r[2];
  end

  // bus protocol engine
  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    ptr_nxt   = ptr_r;
    drive_nxt = drive_r;
    nack_nxt  = nack_r;
    wr_en     = 1'b0;
    if (start_det)
    begin
      state_nxt = rgbdg_pkg::RGBDG_ADDR;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      state_nxt = rgbdg_pkg::RGBDG_IDLE;
      drive_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        rgbdg_pkg::RGBDG_IDLE: ;
        rgbdg_pkg::RGBDG_ADDR, rgbdg_pkg::RGBDG_PTR, rgbdg_pkg::RGBDG_WDAT:
        begin
          if (scl_rise && cnt_r != rgbdg_pkg::BITS_PER_BYTE)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == rgbdg_pkg::BITS_PER_BYTE)
          begin
            cnt_nxt   = 4'h0;
            drive_nxt = 1'b1;
            if (state_r == rgbdg_pkg::RGBDG_ADDR)
            begin
              // a foreign address leaves the bus alone until next start
              if (shift_r[7:1] == DEV_ADDR)
                state_nxt = rgbdg_pkg::RGBDG_AACK;
              else
              begin
                state_nxt = rgbdg_pkg::RGBDG_IDLE;
                drive_nxt = 1'b0;
              end
            end
            else if (state_r == rgbdg_pkg::RGBDG_PTR)
            begin
              ptr_nxt   = shift_r;
              state_nxt = rgbdg_pkg::RGBDG_PACK;
            end
            else
            begin
              wr_en     = 1'b1;
              ptr_nxt   = ptr_r + 8'h01;
              state_nxt = rgbdg_pkg::RGBDG_WACK;
            end
          end
        end
        rgbdg_pkg::RGBDG_AACK:
        begin
          if (scl_fall)
          begin
            if (shift_r[0])
            begin
              shift_nxt = rd_value(ptr_r, green_r, blue_r, ctrl_r);
              drive_nxt = ~shift_nxt[7];
              state_nxt = rgbdg_pkg::RGBDG_RDAT;
            end
            else
            begin
              drive_nxt = 1'b0;
              state_nxt = rgbdg_pkg::RGBDG_PTR;
            end
          end
        end
        rgbdg_pkg::RGBDG_PACK, rgbdg_pkg::RGBDG_WACK:
        begin
          if (scl_fall)
          begin
            drive_nxt = 1'b0;
            state_nxt = rgbdg_pkg::RGBDG_WDAT;
          end
        end
        rgbdg_pkg::RGBDG_RDAT:
        begin
          if (scl_fall)
          begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_nxt == rgbdg_pkg::BITS_PER_BYTE)
            begin
              cnt_nxt   = 4'h0;
              drive_nxt = 1'b0;
              ptr_nxt   = ptr_r + 8'h01;
              state_nxt = rgbdg_pkg::RGBDG_RACK;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              drive_nxt = ~shift_nxt[7];
            end
          end
        end
        rgbdg_pkg::RGBDG_RACK:
        begin
          if (scl_rise)
            nack_nxt = sda_s;
          else if (scl_fall)
          begin
            if (nack_r)
              state_nxt = rgbdg_pkg::RGBDG_IDLE;
            else
            begin
              shift_nxt = rd_value(ptr_r, green_r, blue_r, ctrl_r);
              drive_nxt = ~shift_nxt[7];
              state_nxt = rgbdg_pkg::RGBDG_RDAT;
            end
          end
        end
        default:
        begin
          state_nxt = rgbdg_pkg::RGBDG_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  // register file and pin levels
  always_comb
  begin
    green_nxt = green_r;
    blue_nxt  = blue_r;
    ctrl_nxt  = ctrl_r;
    if (wr_en)
    begin
      case (ptr_r)
        rgbdg_pkg::GREEN_OFS: green_nxt = shift_r;
        rgbdg_pkg::BLUE_OFS:  blue_nxt  = shift_r;
        rgbdg_pkg::CTRL_OFS:  ctrl_nxt  = shift_r & rgbdg_pkg::CTRL_WMASK;
        default: ;
      endcase
    end
    lvl = {ctrl_r[rgbdg_pkg::PIN3_LVL_BIT], ctrl_r[rgbdg_pkg::PIN2_LVL_BIT],
           ctrl_r[rgbdg_pkg::PIN1_LVL_BIT]};
    // regulator mode drives neither level; the regulator owns the pin
    if (ctrl_r[rgbdg_pkg::MODE_BIT])
    begin
      pin_low_nxt  = lvl;
      pin_high_nxt = ~lvl;
    end
    else
    begin
      pin_low_nxt  = 3'h0;
      pin_high_nxt = 3'h0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r    <= rgbdg_pkg::RGBDG_IDLE;
      shift_r    <= 8'h00;
      cnt_r      <= 4'h0;
      ptr_r      <= 8'h00;
      drive_r    <= 1'b0;
      nack_r     <= 1'b0;
      green_r    <= rgbdg_pkg::CODE_RST;
      blue_r     <= rgbdg_pkg::CODE_RST;
      ctrl_r     <= rgbdg_pkg::CTRL_RST;
      pin_low_o  <= 3'h0;
      pin_high_o <= 3'h0;
      gpo_mode_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      sda_o      <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      shift_r    <= shift_nxt;
      cnt_r      <= cnt_nxt;
      ptr_r      <= ptr_nxt;
      drive_r    <= drive_nxt;
      nack_r     <= nack_nxt;
      green_r    <= green_nxt;
      blue_r     <= blue_nxt;
      ctrl_r     <= ctrl_nxt;
      pin_low_o  <= pin_low_nxt;
      pin_high_o <= pin_high_nxt;
      gpo_mode_o <= ctrl_r[rgbdg_pkg::MODE_BIT];
      sda_oe_n_o <= ~drive_nxt;
      sda_o      <= 1'b0;
    end
  end

  assign green_code_o  = green_r;
  assign blue_code_o   = blue_r;
  assign steps_code[0] = green_r;
  assign steps_code[1] = blue_r;
  assign green_steps_o = steps_out[0];
  assign blue_steps_o  = steps_out[1];

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_sink
    rgbdg_sink_steps u_steps (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .code_i  (steps_code[ch]),
      .steps_o (steps_out[ch])
    );
  end
endmodule // rgbdg_regs

/* test/rgbdg_regs_assertions.sv */
// port checker for the dimming and output mode register bank
`timescale 1ns/10ps
module rgbdg_regs_chk (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       sda_oe_n_o,
  input wire logic [7:0] green_code_o,
  input wire logic [7:0] blue_code_o,
  input wire logic [8:0] green_steps_o,
  input wire logic [8:0] blue_steps_o,
  input wire logic       gpo_mode_o,
  input wire logic [2:0] pin_low_o,
  input wire logic [2:0] pin_high_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_codes: assert property ($rose(rst_n_i) |->
    green_code_o == 8'h01 && blue_code_o == 8'h01)
    else $error("colour code not at default after reset");
  a_green_steps: assert property (
    green_steps_o == {1'h0, $past(green_code_o)} + 9'h001)
    else $error("green step count wrong");
  a_blue_steps: assert property (
    blue_steps_o == {1'h0, $past(blue_code_o)} + 9'h001)
    else $error("blue step count wrong");
  a_max_current: assert property (blue_code_o == 8'hff |=>
    blue_steps_o == 9'h100)
    else $error("full code not at top step");
  a_regulator_mode: assert property (!gpo_mode_o |->
    pin_low_o == 3'h0 && pin_high_o == 3'h0)
    else $error("pins driven in regulator mode");
  a_gpo_levels: assert property (gpo_mode_o |->
    (pin_low_o ^ pin_high_o) == 3'h7)
    else $error("pin neither low nor high");
  a_level_flip: assert property (
    gpo_mode_o && $past(gpo_mode_o) && $changed(pin_low_o)
    |-> $changed(pin_high_o))
    else $error("high level not following low level");
  a_ctrl_reset: assert property ($rose(rst_n_i) |->
    !gpo_mode_o && pin_low_o == 3'h0)
    else $error("control not cleared after reset");
  c_gpo_on: cover property ($rose(gpo_mode_o));
  c_green_max: cover property (green_steps_o == 9'h100);
  c_ack: cover property ($fell(sda_oe_n_o));
endmodule // rgbdg_regs_chk

bind rgbdg_regs rgbdg_regs_chk u_rgbdg_regs_chk (
  .clock_i       (clock_i),
  .rst_n_i       (rst_n_i),
  .sda_oe_n_o    (sda_oe_n_o),
  .green_code_o  (green_code_o),
  .blue_code_o   (blue_code_o),
  .green_steps_o (green_steps_o),
  .blue_steps_o  (blue_steps_o),
  .gpo_mode_o    (gpo_mode_o),
  .pin_low_o     (pin_low_o),
  .pin_high_o    (pin_high_o)
);

/* test/rgbdg_host.sv */
// i2c controller model driving the bank's bus pins
`timescale 1ns/10ps
module rgbdg_host (
  input  wire logic clock_i,
  input  wire logic sda_w_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // 8 clocks a phase, double the minimum the synchroniser needs
  task automatic ph;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic start;
    sda_o <= 1'h1;
    ph;
    scl_o <= 1'h1;
    ph;
    sda_o <= 1'h0;
    ph;
    scl_o <= 1'h0;
    ph;
  endtask
  task automatic stop;
    sda_o <= 1'h0;
    ph;
    scl_o <= 1'h1;
    ph;
    sda_o <= 1'h1;
    ph;
  endtask
  // nine bits, msb first; a 1 releases the line so the target can drive
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      sda_o <= d[i];
      ph;
      scl_o <= 1'h1;
      ph;
      q[i] = sda_w_i;
      scl_o <= 1'h0;
      ph;
    end
  endtask
endmodule // rgbdg_host

/* test/testbench.sv */
// self-checking bench for the dimming and output mode register bank
`timescale 1ns/10ps
module testbench;
  logic       clock_i = 1'h0;
  logic       rst_n_i = 1'h0;
  logic       scl, host_sda, dut_sda, dut_oe_n, sda_w, gpo;
  logic [7:0] green, blue, rd;
  logic [8:0] g_steps, b_steps, q;
  logic [2:0] p_low, p_high, e;
  logic [7:0] codes [3] = '{8'h00, 8'h7f, 8'hff};
  logic [7:0] ctl [5] = '{8'hff, 8'h90, 8'h88, 8'h84, 8'h1c};
  int         mismatches = 0;
  int         checked = 0;
  int         cycles = 0;
  // open-drain wire with pull-up
  assign sda_w = host_sda & (dut_oe_n | dut_sda);
  always #5 clock_i = ~clock_i;
  rgbdg_regs u_rgbdg_regs (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n),
    .green_code_o(green), .blue_code_o(blue), .green_steps_o(g_steps),
    .blue_steps_o(b_steps), .gpo_mode_o(gpo), .pin_low_o(p_low),
    .pin_high_o(p_high));
  rgbdg_host u_rgbdg_host (.clock_i(clock_i), .sda_w_i(sda_w),
    .scl_o(scl), .sda_o(host_sda));
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic byte_w(input logic [7:0] b);
    u_rgbdg_host.xfer({b, 1'h1}, q);
    cmp({8'h00, q[0]}, 9'h000);
  endtask
  task automatic addr(input logic rw);
    u_rgbdg_host.start;
    byte_w({rgbdg_pkg::DEV_ADDR_DFLT, rw});
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [15:0] d,
                    input logic two);
    addr(1'h0);
    byte_w(ofs);
    if (two)
      byte_w(d[15:8]);
    byte_w(d[7:0]);
    u_rgbdg_host.stop;
  endtask
  task automatic chk_rd(input logic [7:0] ofs, input logic [7:0] exp);
    addr(1'h0);
    byte_w(ofs);
    addr(1'h1);
    u_rgbdg_host.xfer(9'h1ff, q);
    u_rgbdg_host.stop;
    cmp({1'h0, q[8:1]}, {1'h0, exp});
  endtask
  // two-byte read: the host acks the first byte, naks the second
  task automatic chk_rd2(input logic [7:0] ofs, input logic [15:0] exp);
    addr(1'h0);
    byte_w(ofs);
    addr(1'h1);
    u_rgbdg_host.xfer(9'h1fe, q);
    cmp({1'h0, q[8:1]}, {1'h0, exp[15:8]});
    u_rgbdg_host.xfer(9'h1ff, q);
    u_rgbdg_host.stop;
    cmp({1'h0, q[8:1]}, {1'h0, exp[7:0]});
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      conclude;
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    chk_rd(8'h22, 8'h01);
    chk_rd(8'h23, 8'h01);
    chk_rd(8'h24, 8'h00);
    cmp(g_steps, 9'h002);
    cmp({6'h00, p_low | p_high}, 9'h000);
    // burst write exercises pointer auto-increment into blue
    foreach (codes[i])
    begin
      wr(8'h22, {codes[i], ~codes[i]}, 1'h1);
      cmp({1'h0, green}, {1'h0, codes[i]});
      cmp({1'h0, blue}, {1'h0, ~codes[i]});
      cmp(g_steps, {1'h0, codes[i]} + 9'h001);
      cmp(b_steps, {1'h0, ~codes[i]} + 9'h001);
      chk_rd(8'h23, ~codes[i]);
    end
    foreach (ctl[i])
    begin
      wr(8'h24, {8'h00, ctl[i]}, 1'h0);
      e = ctl[i][7] ? {ctl[i][2], ctl[i][3], ctl[i][4]} : 3'h0;
      cmp({8'h00, gpo}, {8'h00, ctl[i][7]});
      cmp({6'h00, p_low}, {6'h00, e});
      cmp({6'h00, p_high}, ctl[i][7] ? {6'h00, ~e} : 9'h000);
      chk_rd(8'h24, ctl[i] & 8'h9c);
    end
    chk_rd(8'h30, 8'h00);
    // second reset with non-default contents must restore power-on values
    rst_n_i <= 1'h0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    chk_rd2(8'h22, 16'h0101);
    chk_rd(8'h24, 8'h00);
    cmp({8'h00, gpo}, 9'h000);
    cmp(b_steps, 9'h002);
    conclude;
  end
endmodule // testbench
